/* File: logic/acc_pkg.sv */
// Purpose: Constants and types for the accumulator add and AND datapath
// Assumes: 8-bit data path, AXI4-Lite register access with 32-bit data
// Notes: Flag bit positions follow the status byte layout of the core
//
// Overview of operation
// - Sum adds working register to memory, four flags
// - Sum written back to memory, working register kept
// - Memory AND working register updates only zero flag
// - AND to working register leaves memory untouched
// - Literal AND into working register, zero flag only
// - AND of memory and working register stored back
package acc_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_OFS_WORK = 8'h00;
  localparam logic [7:0] ACC_OFS_FLAGS = 8'h04;
  localparam logic [7:0] ACC_OFS_MEM = 8'h08;
  localparam logic [7:0] ACC_OFS_LIT = 8'h0C;
  localparam logic [7:0] ACC_OFS_CMD = 8'h10;
  localparam logic [7:0] ACC_OFS_RES = 8'h14;
  // ----------------------------------------------------------------
  // Flag positions and reset values
  // ----------------------------------------------------------------
  localparam int ACC_FLAG_SUM_SPILL = 0;
  localparam int ACC_FLAG_NULL = 1;
  localparam int ACC_FLAG_NIBBLE = 2;
  localparam int ACC_FLAG_SIGNED = 3;
  localparam logic [7:0] ACC_WORK_RST = 8'h00;
  localparam logic [3:0] ACC_FLAGS_RST = 4'h0;
  localparam logic [7:0] ACC_MEM_RST = 8'h00;
  localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ACC_OP_SUM_INTO_MEMORY,
    ACC_OP_MASK_MEMORY_INTO_WORKING,
    ACC_OP_MASK_LITERAL_INTO_WORKING,
    ACC_OP_MASK_INTO_MEMORY
  } acc_op_type;
endpackage

/* File: logic/acc_alu.sv */
// Purpose: Combinational add and AND unit with flag results
// Assumes: Operands are bytes; flags are packed as in acc_pkg
// Notes: Flags not affected by the operation keep their old value
`timescale 1ns/1ps
module acc_alu
  import acc_pkg::*;
(
  input wire acc_op_type op_i, // Operation to perform
  input wire logic [7:0] work_i, // Working register
  input wire logic [7:0] mem_i, // Memory operand
  input wire logic [7:0] lit_i, // Immediate literal
  input wire logic [3:0] flags_i, // Current flags
  output logic [7:0] result_o, // Operation result
  output logic [3:0] flags_o, // Updated flags
  output logic to_work_o // Result goes to working register
);
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] and_b;
  logic signed_spill;

  assign sum = {1'b0, work_i} + {1'b0, mem_i};
  assign low_sum = {1'b0, work_i[3:0]} + {1'b0, mem_i[3:0]};
  assign signed_spill = (work_i[7] == mem_i[7]) && (sum[7] != work_i[7]);
  assign and_b = (op_i == ACC_OP_MASK_LITERAL_INTO_WORKING) ? lit_i : mem_i;
  assign to_work_o = (op_i == ACC_OP_MASK_MEMORY_INTO_WORKING) ||
                     (op_i == ACC_OP_MASK_LITERAL_INTO_WORKING);

  always_comb begin
    flags_o = flags_i;
    if (op_i == ACC_OP_SUM_INTO_MEMORY) begin
      result_o = sum[7:0];
      flags_o[ACC_FLAG_SUM_SPILL] = sum[8];
      flags_o[ACC_FLAG_NIBBLE] = low_sum[4];
      flags_o[ACC_FLAG_SIGNED] = signed_spill;
      flags_o[ACC_FLAG_NULL] = (sum[7:0] == 8'h00);
    end else begin
      result_o = work_i & and_b;
      flags_o[ACC_FLAG_NULL] = ((work_i & and_b) == 8'h00);
    end
  end
endmodule

/* File: logic/acc_top.sv */
// Purpose: Accumulator add and AND datapath with AXI4-Lite registers
// Assumes: Single clock, synchronous reset, one outstanding access each
// Notes: Writing the command register executes one operation
`timescale 1ns/1ps
module acc_top
  import acc_pkg::*;
(
  input wire logic clk_i, // 20 MHz core clock
  input wire logic srst_i, // Synchronous reset, active high
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Decode drops the two low address bits, so every offset has to
  // sit on a word boundary
  if (|((ACC_OFS_WORK | ACC_OFS_FLAGS | ACC_OFS_MEM | ACC_OFS_LIT |
         ACC_OFS_CMD | ACC_OFS_RES) & 8'h03)) begin : g_ofs_chk
    $error("register offsets must be word aligned");
  end

  // ----------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------
  // Byte lanes inside one word select the same register
  function automatic logic [7:0] word_addr(input logic [7:0] a);
    return {a[7:2], 2'b00};
  endfunction

  // Mapped offsets answer OKAY, all others SLVERR
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == ACC_OFS_WORK) || (a == ACC_OFS_FLAGS) ||
           (a == ACC_OFS_MEM) || (a == ACC_OFS_LIT) ||
           (a == ACC_OFS_CMD) || (a == ACC_OFS_RES);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] work_q, work_d;
  logic [7:0] mem_q, mem_d;
  logic [7:0] lit_q, lit_d;
  logic [7:0] res_q, res_d;
  logic [3:0] flags_q, flags_d;
  logic [7:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_have_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ----------------------------------------------------------------
  // Write channel decode
  // ----------------------------------------------------------------
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_have_q && w_have_q && !bvalid_q;
  wire lane0 = wstrb_q[0];
  wire wr_work = do_write && lane0 && (awaddr_q == ACC_OFS_WORK);
  wire wr_flags = do_write && lane0 && (awaddr_q == ACC_OFS_FLAGS);
  wire wr_mem = do_write && lane0 && (awaddr_q == ACC_OFS_MEM);
  wire wr_lit = do_write && lane0 && (awaddr_q == ACC_OFS_LIT);
  wire wr_cmd = do_write && lane0 && (awaddr_q == ACC_OFS_CMD);
  wire wr_known = is_mapped(awaddr_q);

  // Each channel parks one item; the next waits for the response
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  acc_op_type op;
  logic [7:0] alu_res;
  logic [3:0] alu_flags;
  logic alu_to_work;

  assign op = acc_op_type'(wdata_q[1:0]);

  acc_alu u_alu (
    .op_i(op),
    .work_i(work_q),
    .mem_i(mem_q),
    .lit_i(lit_q),
    .flags_i(flags_q),
    .result_o(alu_res),
    .flags_o(alu_flags),
    .to_work_o(alu_to_work)
  );

  always_comb begin
    work_d = work_q;
    mem_d = mem_q;
    lit_d = lit_q;
    res_d = res_q;
    flags_d = flags_q;
    if (wr_work) begin
      work_d = wdata_q[7:0];
    end
    if (wr_mem) begin
      mem_d = wdata_q[7:0];
    end
    if (wr_lit) begin
      lit_d = wdata_q[7:0];
    end
    if (wr_flags) begin
      flags_d = wdata_q[3:0];
    end
    // Command runs on the registers as they stand; no other write
    // can share the cycle, so nothing is overridden
    if (wr_cmd) begin
      flags_d = alu_flags;
      res_d = alu_res;
      if (alu_to_work) begin
        work_d = alu_res;
      end else begin
        mem_d = alu_res;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      work_q <= ACC_WORK_RST;
      mem_q <= ACC_MEM_RST;
      lit_q <= ACC_MEM_RST;
      res_q <= ACC_MEM_RST;
      flags_q <= ACC_FLAGS_RST;
    end else begin
      work_q <= work_d;
      mem_q <= mem_d;
      lit_q <= lit_d;
      res_q <= res_d;
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------------------------------
  // Write handshake
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= ACC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q <= word_addr(s_axi_awaddr);
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // Read data is captured at the address handshake
  wire [7:0] ra = word_addr(s_axi_araddr);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_known = is_mapped(ra);
  wire [7:0] rd_byte = (ra == ACC_OFS_WORK) ? work_q :
                       (ra == ACC_OFS_FLAGS) ? {4'h0, flags_q} :
                       (ra == ACC_OFS_MEM) ? mem_q :
                       (ra == ACC_OFS_LIT) ? lit_q :
                       (ra == ACC_OFS_RES) ? res_q : 8'h00;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= ACC_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_known ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule

/* File: verification/acc_chk.sv */
// Purpose: Bus timing checks at the block ports
// Assumes: Single clock, synchronous reset
// Notes: Bound to acc_top from the bench
`timescale 1ns/1ps
module acc_chk (
  input wire logic clk_i, srst_i,
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  r_late_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  b_late_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  rd_upper_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("bvalid kept");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("rvalid kept");
  wr_c: cover property (s_axi_bvalid && s_axi_bready);
  rd_c: cover property (s_axi_rvalid && s_axi_rready);
  err_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

/* File: verification/acc_mst.sv */
// Purpose: Bus master model standing for the core side
// Assumes: One access at a time
// Notes: Released address and data lines show inverted values
`timescale 1ns/1ps
module acc_mst (
  input wire logic clk_i, srst_i,
  input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid,
  input wire logic s_axi_arready, s_axi_rvalid,
  output logic [7:0] s_axi_awaddr, s_axi_araddr,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready,
  output logic s_axi_arvalid, s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, sa, sw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk_i);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (pa || pw) begin
      @(negedge clk_i);
      {sa, sw} = {s_axi_awready, s_axi_wready};
      @(posedge clk_i);
      if (pa && sa === 1'b1) begin
        pa = 1'b0;
        {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      end
      if (pw && sw === 1'b1) begin
        pw = 1'b0;
        {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      end
    end
    while (s_axi_bvalid !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    @(negedge clk_i);
    while (s_axi_arready !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
    @(negedge clk_i);
    while (s_axi_rvalid !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    s_axi_rready <= 1'b0;
  endtask
endmodule

/* File: verification/accumulator_add_and_ops_tb.sv */
// Purpose: Self-checking bench for the add and AND datapath
// Assumes: Reads and responses are checked against queued notes
// Notes: Random operands, every operation, zero results forced
`timescale 1ns/1ps
module accumulator_add_and_ops_tb;
  import acc_pkg::*;
  logic clk_i, srst_i;
  logic [7:0] s_axi_awaddr, s_axi_araddr, w, m, l, r;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, ef;
  logic [1:0] s_axi_bresp, s_axi_rresp, op;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [8:0] s;
  logic [4:0] h;
  int bad_count, comparisons;
  logic [33:0] rq[$], bq[$];
  acc_top u_dut (.*);
  acc_mst u_mst (.*);
  task automatic check(input string n, input logic [33:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d, input logic [1:0] e);
    bq.push_back({32'h0, e});
    u_mst.wr(a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a, d, input logic [1:0] e);
    rq.push_back({e, 24'h0, d});
    u_mst.rd(a);
  endtask
  // ----------------------------------------
  // Monitor takes the oldest note per answer
  // ----------------------------------------
  always @(negedge clk_i) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      check("read word", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      check("write resp", {32'h0, s_axi_bresp}, bq.pop_front());
  end
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    #400000;
    bad_count++;
    close_out();
  end
  initial begin
    bad_count = 0;
    comparisons = 0;
    srst_i = 1'b1;
    void'($urandom(87));
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int a = 0; a < 24; a += 4) rd(a[7:0], 8'h00, ACC_RESP_OKAY);
    rd(8'h18, 8'h00, ACC_RESP_SLVERR);
    wr(8'h1C, 8'h5A, ACC_RESP_SLVERR);
    for (int i = 0; i < 32; i++) begin
      op = i[1:0];
      {w, m, l, ef} = 28'($urandom);
      if (i % 8 > 3) {m, l} = {(op == 2'h0) ? -w : ~w, ~w};
      wr(ACC_OFS_WORK, w, ACC_RESP_OKAY);
      wr(ACC_OFS_MEM, m, ACC_RESP_OKAY);
      wr(ACC_OFS_LIT, l, ACC_RESP_OKAY);
      wr(ACC_OFS_FLAGS, {4'h0, ef}, ACC_RESP_OKAY);
      wr(ACC_OFS_CMD, {6'h0, op}, ACC_RESP_OKAY);
      s = {1'b0, w} + {1'b0, m};
      h = {1'b0, w[3:0]} + {1'b0, m[3:0]};
      r = (op == 2'h0) ? s[7:0] : (op == 2'h2) ? (w & l) : (w & m);
      ef = (op == 2'h0) ? {w[7] == m[7] && r[7] != w[7], h[4],
        r == 8'h00, s[8]} : {ef[3:2], r == 8'h00, ef[0]};
      rd(ACC_OFS_WORK, op inside {2'h1, 2'h2} ? r : w, 2'h0);
      rd(ACC_OFS_MEM, op inside {2'h0, 2'h3} ? r : m, 2'h0);
      rd(ACC_OFS_FLAGS, {4'h0, ef}, ACC_RESP_OKAY);
      rd(ACC_OFS_RES, r, ACC_RESP_OKAY);
    end
    wr(ACC_OFS_RES, ~r, ACC_RESP_OKAY);
    rd(ACC_OFS_RES, r, ACC_RESP_OKAY);
    rd(ACC_OFS_CMD, 8'h00, ACC_RESP_OKAY);
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int a = 0; a < 24; a += 4) rd(a[7:0], 8'h00, ACC_RESP_OKAY);
    check("notes left", 34'(rq.size() + bq.size()), 34'h0);
    close_out();
  end
endmodule
bind acc_top acc_chk u_chk (.*);
